// >>> coil_drive_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "coil_params.svh"
module coil_drive_mode_control #(
	parameter int TIMEOUT_CYCLES = `SCL_TIMEOUT_CYCLES,
	parameter int CODE_W = 10
)(
	// Clocking
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	// Pins and analog monitors
	input wire logic scl_pin,
	input wire logic overtemp_fault,
	input wire logic coil_short_fault,
	input wire logic coil_open_fault,
	input wire logic current_limit_trip,
	input wire logic sense_above_target,
	// Output stage
	output logic stage_enable,
	output logic linear_source_on,
	output logic high_side_on,
	output logic low_side_on,
	output logic [CODE_W-1:0] dac_code,
	output coil_pkg::power_state_t power_state
);
	generate
		if (CODE_W != 10 || TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > 131071)
		begin : g_bad
			$error("coil_drive_mode_control: unsupported parameters");
		end
	endgenerate

	function automatic logic hit(input logic [7:0] a, input logic [7:0] offset);
		hit = (a == offset);
	endfunction

	function automatic logic [7:0] pwm_period(input coil_pkg::pwm_freq_t f);
		case (f)
			coil_pkg::FREQ_0M5: pwm_period = 8'(`CLK_FREQ_KHZ / `PWM_KHZ_0);
			coil_pkg::FREQ_1M: pwm_period = 8'(`CLK_FREQ_KHZ / `PWM_KHZ_1);
			coil_pkg::FREQ_2M: pwm_period = 8'(`CLK_FREQ_KHZ / `PWM_KHZ_2);
			default: pwm_period = 8'(`CLK_FREQ_KHZ / `PWM_KHZ_3);
		endcase
	endfunction

	// Pin synchronisers; stage one is read only by stage two
	logic [5:0] sync_a;
	logic [5:0] sync_b;
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			sync_a <= 6'h01;
			sync_b <= 6'h01;
		end
		else if (ce)
		begin
			sync_a <= {sense_above_target, current_limit_trip, coil_open_fault,
				coil_short_fault, overtemp_fault, scl_pin};
			sync_b <= sync_a;
		end
	end
	logic scl_s;
	logic ot_s;
	logic short_s;
	logic open_s;
	logic above_s;
	assign scl_s = sync_b[0];
	assign ot_s = sync_b[1];
	assign short_s = sync_b[2] | sync_b[4];
	assign open_s = sync_b[3];
	assign above_s = sync_b[5];

	// Mode and register state
	coil_pkg::power_state_t state;
	coil_pkg::power_state_t next_state;
	logic [16:0] low_cnt;
	logic [16:0] next_low_cnt;
	logic [CODE_W-1:0] code;
	logic [CODE_W-1:0] next_code;
	coil_pkg::pwm_freq_t freq;
	coil_pkg::pwm_freq_t next_freq;
	logic pwm_style;
	logic next_pwm_style;
	logic [7:0] resonance_setting;
	logic [7:0] next_resonance_setting;
	logic [2:0] status;
	logic [2:0] next_status;
	logic [15:0] next_reg_rdata;
	logic fault_any;
	logic timeout;
	logic wr_ok;
	logic restart;

	always_comb
	begin
		fault_any = ot_s | short_s | open_s;
		timeout = !scl_s && (low_cnt >= 17'(TIMEOUT_CYCLES - 1));
		// Shutdown ignores bus writes, though reads are still answered: the serial port is down there
		wr_ok = reg_write && (state != coil_pkg::ST_SHUTDOWN);
		restart = wr_ok && hit(reg_addr, `ADDR_CONTROL) && reg_wdata[`CTRL_RESTART_BIT];
		next_low_cnt = scl_s ? 17'h00000 : (timeout ? low_cnt : low_cnt + 17'h00001);
		next_state = state;
		next_code = code;
		next_freq = freq;
		next_pwm_style = pwm_style;
		next_resonance_setting = resonance_setting;
		next_status = status;
		if (wr_ok && hit(reg_addr, `ADDR_CONTROL))
			next_freq = coil_pkg::pwm_freq_t'(reg_wdata[`CTRL_FREQ_LSB +: 2]);
		if (wr_ok && hit(reg_addr, `ADDR_MODE))
			next_pwm_style = reg_wdata[`MODE_PWM_BIT];
		if (wr_ok && hit(reg_addr, `ADDR_RESONANCE))
			next_resonance_setting = reg_wdata[7:0];
		if (wr_ok && hit(reg_addr, `ADDR_CURRENT))
			next_code = reg_wdata[CODE_W-1:0];
		case (state)
			coil_pkg::ST_SHUTDOWN:
			begin
				if (scl_s)
				begin
					next_state = coil_pkg::ST_STANDBY;
					next_code = `CURRENT_RESET;
					next_freq = coil_pkg::pwm_freq_t'(`CONTROL_RESET);
					next_pwm_style = `MODE_RESET;
					next_resonance_setting = `RESONANCE_RESET;
					next_status = 3'h0;
				end
			end
			coil_pkg::ST_STANDBY:
			begin
				if (next_code != '0)
				begin
					next_state = coil_pkg::ST_ACTIVE;
					next_status = 3'h0;
				end
			end
			coil_pkg::ST_ACTIVE:
			begin
				if (fault_any)
				begin
					next_state = coil_pkg::ST_STANDBY;
					next_code = '0;
					next_status = status | {open_s, short_s, ot_s};
				end
				else if (next_code == '0)
					next_state = coil_pkg::ST_STANDBY;
			end
			default:
				next_state = coil_pkg::ST_SHUTDOWN;
		endcase
		if (restart)
		begin
			next_state = (state == coil_pkg::ST_SHUTDOWN) ? state : coil_pkg::ST_STANDBY;
			next_code = `CURRENT_RESET;
			next_freq = coil_pkg::pwm_freq_t'(`CONTROL_RESET);
			next_pwm_style = `MODE_RESET;
			next_resonance_setting = `RESONANCE_RESET;
			next_status = (state == coil_pkg::ST_ACTIVE) ? {open_s, short_s, ot_s} : 3'h0;
		end
		if (timeout)
		begin
			next_state = coil_pkg::ST_SHUTDOWN;
			next_code = '0;
		end
		next_reg_rdata = 16'h0000;
		if (reg_read)
		begin
			if (hit(reg_addr, `ADDR_CONTROL))
				next_reg_rdata[`CTRL_FREQ_LSB +: 2] = freq;
			else if (hit(reg_addr, `ADDR_MODE))
				next_reg_rdata[`MODE_PWM_BIT] = pwm_style;
			else if (hit(reg_addr, `ADDR_CURRENT))
				next_reg_rdata[CODE_W-1:0] = code;
			else if (hit(reg_addr, `ADDR_STATUS))
				next_reg_rdata = {10'h000, state, 1'b0, status};
			else if (hit(reg_addr, `ADDR_RESONANCE))
				next_reg_rdata[7:0] = resonance_setting;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state <= coil_pkg::ST_STANDBY;
			low_cnt <= 17'h00000;
			code <= `CURRENT_RESET;
			freq <= coil_pkg::pwm_freq_t'(`CONTROL_RESET);
			pwm_style <= `MODE_RESET;
			resonance_setting <= `RESONANCE_RESET;
			status <= 3'h0;
			reg_rdata <= 16'h0000;
		end
		else if (ce)
		begin
			state <= next_state;
			low_cnt <= next_low_cnt;
			code <= next_code;
			freq <= next_freq;
			pwm_style <= next_pwm_style;
			resonance_setting <= next_resonance_setting;
			status <= next_status;
			reg_rdata <= next_reg_rdata;
		end
	end

	assign power_state = state;

	// Ramped drive level feeds the DAC
	logic [CODE_W-1:0] ramp_level;
	coil_ramp #(.CODE_W(CODE_W), .BASE_CYCLES(`RAMP_BASE_CYCLES)) u_ramp (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.enable(state == coil_pkg::ST_ACTIVE),
		.target(code),
		.resonance_setting(resonance_setting),
		.level(ramp_level),
		.settled()
	);

	// Output stage
	logic [7:0] pwm_cnt;
	logic [7:0] next_pwm_cnt;
	logic next_stage_enable;
	logic next_linear_source_on;
	logic next_high_side_on;
	logic next_low_side_on;
	logic pwm_run;

	always_comb
	begin
		next_stage_enable = (next_state == coil_pkg::ST_ACTIVE);
		pwm_run = next_stage_enable && next_pwm_style;
		next_linear_source_on = next_stage_enable && !next_pwm_style;
		next_pwm_cnt = 8'h00;
		next_high_side_on = 1'b0;
		next_low_side_on = 1'b0;
		if (pwm_run)
		begin
			next_pwm_cnt = (pwm_cnt >= pwm_period(freq) - 8'h01) ? 8'h00 : pwm_cnt + 8'h01;
			// Charge until the sensed current passes the DAC level, then freewheel
			if (next_pwm_cnt == 8'h00)
				next_high_side_on = 1'b1;
			else if (high_side_on && !above_s)
				next_high_side_on = 1'b1;
			next_low_side_on = !next_high_side_on;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			pwm_cnt <= 8'h00;
			stage_enable <= 1'b0;
			linear_source_on <= 1'b0;
			high_side_on <= 1'b0;
			low_side_on <= 1'b0;
			dac_code <= '0;
		end
		else if (ce)
		begin
			pwm_cnt <= next_pwm_cnt;
			stage_enable <= next_stage_enable;
			linear_source_on <= next_linear_source_on;
			high_side_on <= next_high_side_on;
			low_side_on <= next_low_side_on;
			dac_code <= ramp_level;
		end
	end

	chk_timeout_entry: assert property (@(posedge clk) disable iff (reset)
		ce && !scl_s && low_cnt == 17'(TIMEOUT_CYCLES - 1) |=> state == coil_pkg::ST_SHUTDOWN)
		else $error("SCL timeout did not shut down");
	chk_hold_shutdown: assert property (@(posedge clk) disable iff (reset)
		ce && state == coil_pkg::ST_SHUTDOWN && !scl_s |=> state == coil_pkg::ST_SHUTDOWN)
		else $error("Left shutdown while SCL low");
	chk_wake_defaults: assert property (@(posedge clk) disable iff (reset)
		ce && state == coil_pkg::ST_SHUTDOWN && scl_s
		|=> state == coil_pkg::ST_STANDBY && code == '0 && status == 3'h0 && !pwm_style)
		else $error("Wake did not restore defaults");
	chk_enter_active: assert property (@(posedge clk) disable iff (reset)
		ce && state == coil_pkg::ST_STANDBY && wr_ok && hit(reg_addr, `ADDR_CURRENT)
		&& reg_wdata[CODE_W-1:0] != '0 && !fault_any && !timeout
		|=> state == coil_pkg::ST_ACTIVE)
		else $error("Non-zero code did not activate");
	chk_zero_standby: assert property (@(posedge clk) disable iff (reset)
		code == '0 |-> state != coil_pkg::ST_ACTIVE)
		else $error("Active with zero code");
	chk_soft_restart: assert property (@(posedge clk) disable iff (reset)
		ce && restart && !timeout |=> state == coil_pkg::ST_STANDBY && code == '0)
		else $error("Soft restart not honoured");
	chk_fault_exit: assert property (@(posedge clk) disable iff (reset)
		ce && state == coil_pkg::ST_ACTIVE && fault_any
		|=> state != coil_pkg::ST_ACTIVE && code == '0 && status != 3'h0)
		else $error("Fault did not force standby");
	chk_status_clear: assert property (@(posedge clk) disable iff (reset)
		$rose(state == coil_pkg::ST_ACTIVE) |-> status == 3'h0)
		else $error("Status not cleared on activation");
	chk_stage_active: assert property (@(posedge clk) disable iff (reset)
		stage_enable == (state == coil_pkg::ST_ACTIVE))
		else $error("Stage enable mismatch");
	chk_limit_short: assert property (@(posedge clk) disable iff (reset)
		ce && state == coil_pkg::ST_ACTIVE && sync_b[4] && !restart && !timeout
		|=> status[`STAT_SHORT_BIT] && state == coil_pkg::ST_STANDBY)
		else $error("Current limit not reported as short");
	chk_drive_style: assert property (@(posedge clk) disable iff (reset)
		stage_enable |-> (linear_source_on != pwm_style) && !(high_side_on && low_side_on))
		else $error("Drive style mismatch");
endmodule // coil_drive_mode_control
`default_nettype wire

// >>> coil_params.svh
`ifndef COIL_PARAMS_SVH
`define COIL_PARAMS_SVH

`define CLK_PERIOD_NS 8
`define SCL_TIMEOUT_NS 500000
`define SCL_TIMEOUT_CYCLES ((`SCL_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLK_FREQ_KHZ (1000000 / `CLK_PERIOD_NS)

`define ADDR_CONTROL 8'h02
`define ADDR_MODE 8'h03
`define ADDR_CURRENT 8'h04
`define ADDR_STATUS 8'h05
`define ADDR_RESONANCE 8'h07

`define CTRL_RESTART_BIT 0
`define CTRL_FREQ_LSB 1
`define MODE_PWM_BIT 0
`define STAT_OVERTEMP_BIT 0
`define STAT_SHORT_BIT 1
`define STAT_OPEN_BIT 2
`define STAT_STATE_LSB 4

`define CONTROL_RESET 2'h0
`define MODE_RESET 1'h0
`define CURRENT_RESET 10'h000
`define RESONANCE_RESET 8'h00

`define PWM_KHZ_0 500
`define PWM_KHZ_1 1000
`define PWM_KHZ_2 2000
`define PWM_KHZ_3 4000

`define RAMP_BASE_CYCLES 16
`define RAMP_SCALE_CYCLES 1

`endif

// >>> coil_pkg.sv
package coil_pkg;
	typedef enum logic [1:0]
	{
		ST_SHUTDOWN = 2'h0,
		ST_STANDBY = 2'h1,
		ST_ACTIVE = 2'h3
	} power_state_t;
	typedef enum logic [1:0]
	{
		FREQ_0M5 = 2'h0,
		FREQ_1M = 2'h1,
		FREQ_2M = 2'h2,
		FREQ_4M = 2'h3
	} pwm_freq_t;
endpackage

// >>> coil_ramp.sv
`timescale 1ns/1ps
`default_nettype none
`include "coil_params.svh"
module coil_ramp #(
	parameter int CODE_W = 10,
	parameter int BASE_CYCLES = `RAMP_BASE_CYCLES
)(
	// Clocking
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// Control
	input wire logic enable,
	input wire logic [CODE_W-1:0] target,
	input wire logic [7:0] resonance_setting,
	// Drive level
	output logic [CODE_W-1:0] level,
	output logic settled
);
	generate
		if (CODE_W < 2 || BASE_CYCLES < 1)
		begin : g_bad
			$error("coil_ramp: unsupported parameters");
		end
	endgenerate

	logic [15:0] tick;
	logic [15:0] next_tick;
	logic [CODE_W-1:0] next_level;
	logic [15:0] interval;

	// Lower resonance wants a slower slope so the spring is not kicked
	always_comb
	begin
		interval = 16'(BASE_CYCLES) + 16'(8'hff - resonance_setting) * 16'(`RAMP_SCALE_CYCLES);
		next_tick = tick;
		next_level = level;
		if (!enable)
		begin
			next_tick = 16'h0000;
			next_level = '0;
		end
		else if (level != target)
		begin
			if (tick >= interval - 16'h0001)
			begin
				next_tick = 16'h0000;
				next_level = (level < target) ? level + 1'b1 : level - 1'b1;
			end
			else
				next_tick = tick + 16'h0001;
		end
		else
			next_tick = 16'h0000;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			tick <= 16'h0000;
			level <= '0;
		end
		else if (ce)
		begin
			tick <= next_tick;
			level <= next_level;
		end
	end

	assign settled = (level == target);
endmodule // coil_ramp
`default_nettype wire

// >>> host_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
	// Clocking
	input wire logic clk,
	// Coil side
	input wire logic high_side_on,
	output logic sense_above_target,
	// Serial clock
	output logic scl_pin
);
	initial
	begin
		scl_pin = 1'b1;
		sense_above_target = 1'b0;
	end
	// Coil charges only while the high side conducts, so every period ends in freewheel
	always @(posedge clk)
		sense_above_target <= high_side_on;
	// Frames toggle at the link rate; the line rests high between them
	// Bench link clock runs faster than a real host may; only levels matter here
	task automatic burst(input int n);
		#3;
		repeat (n)
		begin
			#80 scl_pin = 1'b0;
			#80 scl_pin = 1'b1;
		end
	endtask
	task automatic level(input logic v);
		#2 scl_pin = v;
	endtask
endmodule // host_link_model
`default_nettype wire

// >>> coil_drive_mode_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module coil_drive_mode_control_bench;
	typedef struct packed
	{
		logic [15:0] ctrl;
		logic [15:0] mode;
		logic [15:0] code;
		logic [1:0] state;
		logic lin;
		logic [15:0] period;
	} row_t;
	localparam int TMO = 50;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [15:0] reg_rdata;
	logic [3:0] faults = 4'h0;
	logic [3:0] fbit [4] = '{4'h1, 4'h2, 4'h4, 4'h2};
	logic scl_pin, sense_above_target, high_side_on, low_side_on, stage_enable, linear_source_on;
	logic [9:0] dac_code;
	coil_pkg::power_state_t power_state;
	int num_errors = 0;
	int num_checks = 0;
	int p;
	row_t rows [7];
	always #4 clk = ~clk;
	coil_drive_mode_control #(.TIMEOUT_CYCLES(TMO)) u_dut (
		.clk(clk), .reset(reset), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .scl_pin(scl_pin),
		.overtemp_fault(faults[0]), .coil_short_fault(faults[1]),
		.coil_open_fault(faults[2]), .current_limit_trip(faults[3]),
		.sense_above_target(sense_above_target), .stage_enable(stage_enable),
		.linear_source_on(linear_source_on), .high_side_on(high_side_on),
		.low_side_on(low_side_on), .dac_code(dac_code), .power_state(power_state)
	);
	host_link_model u_host (
		.clk(clk), .high_side_on(high_side_on),
		.sense_above_target(sense_above_target), .scl_pin(scl_pin)
	);
	task automatic close_out();
		$display("Checks made %0d, mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask
	task automatic defaults();
		rdc(8'h02, 16'h0000);
		rdc(8'h03, 16'h0000);
		rdc(8'h04, 16'h0000);
		rdc(8'h05, 16'h0010);
		rdc(8'h07, 16'h0000);
	endtask
	// Cycles between two rising edges of the charge phase
	task automatic measure(output int n);
		logic prev;
		int rises;
		int k;
		prev = 1'b1;
		rises = 0;
		n = 0;
		for (k = 0; k < 1000 && rises < 2; k++)
		begin
			cyc(1);
			n++;
			if (high_side_on === 1'b1 && prev !== 1'b1)
			begin
				rises++;
				if (rises == 1)
					n = 0;
			end
			prev = high_side_on;
		end
	endtask
	initial
	begin
		#400000;
		num_errors++;
		close_out();
	end
	initial
	begin
		rows[0] = '{16'h0000, 16'h0000, 16'h0000, 2'h1, 1'b0, 16'd0};
		rows[1] = '{16'h0000, 16'h0000, 16'h0100, 2'h3, 1'b1, 16'd0};
		rows[2] = '{16'h0000, 16'h0001, 16'h03ff, 2'h3, 1'b0, 16'd250};
		rows[3] = '{16'h0002, 16'h0001, 16'h0001, 2'h3, 1'b0, 16'd125};
		rows[4] = '{16'h0004, 16'h0001, 16'h0200, 2'h3, 1'b0, 16'd62};
		rows[5] = '{16'h0006, 16'h0001, 16'h0100, 2'h3, 1'b0, 16'd31};
		rows[6] = '{16'h0006, 16'h0001, 16'h0000, 2'h1, 1'b0, 16'd0};
		cyc(6);
		check(16'(power_state), 16'h0001);
		check(16'(stage_enable), 16'h0000);
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		defaults();
		rdc(8'h10, 16'h0000);
		$display("Reset test done");
		foreach (rows[i])
		begin
			wr(8'h02, rows[i].ctrl);
			wr(8'h03, rows[i].mode);
			wr(8'h04, rows[i].code);
			cyc(6);
			check(16'(power_state), 16'(rows[i].state));
			check(16'(stage_enable), 16'(rows[i].state == 2'h3));
			check(16'(linear_source_on), 16'(rows[i].lin));
			rdc(8'h05, {10'h000, rows[i].state, 4'h0});
			if (rows[i].period != 16'd0)
			begin
				measure(p);
				check(16'(p), rows[i].period);
				cyc(8);
				check(16'({high_side_on, low_side_on}), 16'h0001);
			end
			$display("Row %0d done", i);
		end
		wr(8'h07, 16'h00ff);
		wr(8'h04, 16'h0100);
		cyc(40);
		check(16'(dac_code > 10'h000 && dac_code < 10'h005), 16'h0001);
		// Clock enable low must freeze the ramp between steps
		@(posedge clk) ce <= 1'b0;
		cyc(40);
		check(16'(dac_code), 16'h0002);
		@(posedge clk) ce <= 1'b1;
		wr(8'h02, 16'h0001);
		cyc(4);
		check(16'(power_state), 16'h0001);
		defaults();
		$display("Ramp and restart test done");
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h04, 16'h0100);
			cyc(4);
			rdc(8'h05, 16'h0030);
			@(posedge clk) faults <= 4'h1 << i;
			cyc(5);
			@(posedge clk) faults <= 4'h0;
			cyc(3);
			check(16'(power_state), 16'h0001);
			rdc(8'h04, 16'h0000);
			rdc(8'h05, {12'h001, fbit[i]});
		end
		wr(8'h05, 16'h0000);
		rdc(8'h05, {12'h001, fbit[3]});
		$display("Fault test done");
		wr(8'h04, 16'h0100);
		u_host.burst(16);
		cyc(2);
		check(16'(power_state), 16'h0003);
		u_host.level(1'b0);
		cyc(TMO - 5);
		check(16'(power_state), 16'h0003);
		cyc(15);
		check(16'(power_state), 16'h0000);
		check(16'(stage_enable), 16'h0000);
		wr(8'h04, 16'h0200);
		cyc(20);
		check(16'(power_state), 16'h0000);
		u_host.level(1'b1);
		cyc(5);
		check(16'(power_state), 16'h0001);
		defaults();
		$display("Link timeout test done");
		wr(8'h04, 16'h0100);
		cyc(4);
		@(posedge clk) reset <= 1'b1;
		cyc(2);
		check(16'(power_state), 16'h0001);
		check(16'(stage_enable), 16'h0000);
		check(16'(dac_code), 16'h0000);
		@(posedge clk) reset <= 1'b0;
		defaults();
		wr(8'h04, 16'h0100);
		cyc(2);
		check(16'(power_state), 16'h0003);
		$display("Mid-run reset test done");
		close_out();
	end
endmodule // coil_drive_mode_control_bench
`default_nettype wire
